// ===== core/otpa_defines.vh
// Constants for the one-time programmable bit array access block
`ifndef OTPA_DEFINES_VH
`define OTPA_DEFINES_VH
// Array geometry
`define OTPA_ARRAY_BITS     4096
`define OTPA_BYTE_W         8
`define OTPA_ADDR_W         9
// Value of a never-programmed byte
`define OTPA_BLANK_BYTE     8'h00
// Burn time per byte, nanoseconds, and clock period
`define OTPA_PROG_TIME_NS   1000
`define OTPA_CLK_PERIOD_NS  100
`define OTPA_PROG_CYCLES    ((`OTPA_PROG_TIME_NS + `OTPA_CLK_PERIOD_NS - 1) / `OTPA_CLK_PERIOD_NS)
`endif

// ===== core/otpa_cell_array.v
// Storage cells of the one-time programmable array, registered read port
`timescale 1ns/1ns
module otpa_cell_array #(
    parameter DEPTH  = 512,
    parameter ADDR_W = 9,
    parameter DATA_W = 8
) (
    input  wire              ref_clk,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [DATA_W-1:0] wr_data,
    input  wire [ADDR_W-1:0] rd_addr,
    output reg  [DATA_W-1:0] rd_data
);
    // No reset: cells are non-volatile; initial zeros model a blank part
    reg [DATA_W-1:0] cells [0:DEPTH-1];
    integer i;
    initial
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            cells[i] = {DATA_W{1'b0}};
    end

    always @(posedge ref_clk)
    begin
        if (wr_en)
            cells[wr_addr] <= wr_data;
        rd_data <= cells[rd_addr];
    end
endmodule // otpa_cell_array

// ===== core/otpa_access.v
// Access sequencer for the one-time programmable bit array
// Summary of operation
// - Array holds 4096 bits, addressed as 512 bytes.
// - Reads are accepted from the first cycle after reset release.
// - A blank array reads back all zeros.
// - Programming can only set bits; ones never return to zero.
// - A whole-array pass programs every byte in turn, one write and burn time per byte.
// - Byte programming stores old data ORed with new data.
// - Any byte may hold customer data like vendor and network identifiers.
`timescale 1ns/1ns
`include "otpa_defines.vh"
module otpa_access #(
    parameter ADDR_W     = `OTPA_ADDR_W,
    parameter PROG_CYC   = `OTPA_PROG_CYCLES
) (
    input  wire              ref_clk,
    input  wire              nrst,
    input  wire              rd_req,
    input  wire              prog_req,
    input  wire              prog_all,
    input  wire [ADDR_W-1:0] addr,
    input  wire [7:0]        wdata,
    output reg  [7:0]        rdata_r,
    output reg               rvalid_r,
    output reg               busy_r,
    output reg               prog_done_r
);
    // ********************************************
    // Sequencer states
    // ********************************************
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_RDWAIT = 2'h1;
    localparam [1:0] ST_PROG   = 2'h2;
    localparam [1:0] ST_BURN   = 2'h3;

    // ********************************************
    // Storage and state
    // ********************************************
    localparam DEPTH = `OTPA_ARRAY_BITS / `OTPA_BYTE_W;
    // Last byte ends a whole-array pass
    localparam LAST_BYTE = DEPTH - 1;

    reg  [1:0]        state_r;
    reg  [1:0]        state_nxt;
    reg  [ADDR_W-1:0] ptr_r;
    reg  [ADDR_W-1:0] ptr_nxt;
    reg  [7:0]        wbyte_r;
    reg  [7:0]        wbyte_nxt;
    reg               all_r;
    reg               all_nxt;
    reg  [15:0]       cnt_r;
    reg  [15:0]       cnt_nxt;
    reg               mem_we;
    wire [7:0]        mem_q;

    // Next values of the registered outputs
    reg  [7:0]        rdata_nxt;
    reg               rvalid_nxt;
    reg               busy_nxt;
    reg               prog_done_nxt;

    // Merge keeps every programmed one
    function [7:0] otpa_merge;
        input [7:0] old_v;
        input [7:0] new_v;
        begin
            otpa_merge = old_v | new_v;
        end
    endfunction

    // True while a byte is being written or burnt
    function otpa_is_prog;
        input [1:0] st;
        begin
            otpa_is_prog = (st == ST_PROG) || (st == ST_BURN);
        end
    endfunction

    // ********************************************
    // Cell array
    // ********************************************
    // Read address is the next pointer, so the old byte is ready in PROG
    otpa_cell_array #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (8)
    ) u_cells (
        .ref_clk (ref_clk),
        .wr_en   (mem_we),
        .wr_addr (ptr_r),
        .wr_data (otpa_merge(mem_q, wbyte_r)),
        .rd_addr (ptr_nxt),
        .rd_data (mem_q)
    );

    // ********************************************
    // Sequencer
    // ********************************************
    // Requests are looked at only in idle; anything else is held off
    wire              in_idle   = (state_r == ST_IDLE);
    wire              take_prog = in_idle && prog_req;
    wire              take_rd   = in_idle && rd_req && !prog_req;

    always @*
    begin
        state_nxt = state_r;
        ptr_nxt   = ptr_r;
        wbyte_nxt = wbyte_r;
        all_nxt   = all_r;
        cnt_nxt   = cnt_r;
        mem_we    = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (take_prog)
                begin
                    // Whole pass starts at byte zero with the same pattern
                    ptr_nxt   = prog_all ? {ADDR_W{1'b0}} : addr;
                    wbyte_nxt = wdata;
                    all_nxt   = prog_all;
                    state_nxt = ST_PROG;
                end
                else if (take_rd)
                begin
                    ptr_nxt   = addr;
                    state_nxt = ST_RDWAIT;
                end
            end
            ST_RDWAIT:
                state_nxt = ST_IDLE;
            ST_PROG:
            begin
                // Old byte now on mem_q; merged value written here
                mem_we    = 1'b1;
                cnt_nxt   = PROG_CYC[15:0];
                state_nxt = ST_BURN;
            end
            ST_BURN:
            begin
                // Hold for the cell burn time before the next byte
                if (cnt_r > 16'h0001)
                    cnt_nxt = cnt_r - 16'h0001;
                else if (all_r && ptr_r != LAST_BYTE[ADDR_W-1:0])
                begin
                    ptr_nxt   = ptr_r + 1'b1;
                    state_nxt = ST_PROG;
                end
                else
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // ********************************************
    // Output next values
    // ********************************************
    always @*
    begin
        rdata_nxt     = rdata_r;
        rvalid_nxt    = 1'b0;
        busy_nxt      = otpa_is_prog(state_nxt);
        prog_done_nxt = otpa_is_prog(state_r) && !otpa_is_prog(state_nxt);
        if (state_r == ST_RDWAIT)
        begin
            // Held until the next read, so a slow reader still sees it
            rdata_nxt  = mem_q;
            rvalid_nxt = 1'b1;
        end
    end

    // ********************************************
    // Sequencer registers
    // ********************************************
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            ptr_r   <= {ADDR_W{1'b0}};
            wbyte_r <= `OTPA_BLANK_BYTE;
            all_r   <= 1'b0;
            cnt_r   <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            ptr_r   <= ptr_nxt;
            wbyte_r <= wbyte_nxt;
            all_r   <= all_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ********************************************
    // Output registers
    // ********************************************
    // Every output leaves a flip-flop; no path from pins to pins
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rdata_r     <= `OTPA_BLANK_BYTE;
            rvalid_r    <= 1'b0;
            busy_r      <= 1'b0;
            prog_done_r <= 1'b0;
        end
        else
        begin
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
            busy_r      <= busy_nxt;
            prog_done_r <= prog_done_nxt;
        end
    end
endmodule // otpa_access

// ===== verification/otpa_access_props.sv
// Assertions for the OTP access sequencer
`timescale 1ns/1ns
module otpa_access_props #(
    parameter ADDR_W = 9,
    parameter PROG_CYC = 1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rd_req,
    input wire logic prog_req,
    input wire logic prog_all,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata_r,
    input wire logic rvalid_r,
    input wire logic busy_r,
    input wire logic prog_done_r
);
    // ****
    // Checks
    // ****
    logic [12:0] len_r;
    always @(posedge ref_clk)
        len_r <= (busy_r && nrst) ? len_r + 13'h1 : 13'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_fall;
        busy_r ##1 !busy_r;
    endsequence
    chk_read_lat: assert property (rvalid_r |-> $past(rd_req, 2) && !$past(prog_req, 2))
        else $error("read answer without request");
    chk_read_pulse: assert property (rvalid_r |=> !rvalid_r) else $error("read valid too long");
    chk_rdata_hold: assert property ($changed(rdata_r) |-> rvalid_r) else $error("read data moved");
    chk_busy_cause: assert property ($rose(busy_r) |-> $past(prog_req)) else $error("busy without program");
    // Whole pass spends the byte time on each of 512 bytes
    chk_burn_len: assert property (prog_done_r |-> len_r == PROG_CYC + 1 || len_r == 512 * (PROG_CYC + 1))
        else $error("program length wrong");
    chk_done_fall: assert property (s_fall |-> prog_done_r) else $error("no done at end");
    chk_done_pulse: assert property (prog_done_r |-> !busy_r ##1 !prog_done_r) else $error("done pulse bad");
    chk_busy_quiet: assert property (busy_r |-> !rvalid_r) else $error("read served while busy");
endmodule // otpa_access_props
bind otpa_access otpa_access_props #(.ADDR_W(ADDR_W), .PROG_CYC(PROG_CYC)) u_props (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .rd_req      (rd_req),
    .prog_req    (prog_req),
    .prog_all    (prog_all),
    .addr        (addr),
    .wdata       (wdata),
    .rdata_r     (rdata_r),
    .rvalid_r    (rvalid_r),
    .busy_r      (busy_r),
    .prog_done_r (prog_done_r)
);

// ===== verification/otpa_access_test.sv
// Self-checking bench for the OTP access sequencer
`timescale 1ns/1ns
module otpa_access_test;
    // ****
    // Stimulus
    // ****
    logic ref_clk = 1'b0, nrst = 1'b0, rd_req = 1'b0, prog_req = 1'b0, prog_all = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    wire [7:0] rdata_r;
    wire rvalid_r, busy_r, prog_done_r;
    int miscompares = 0, compares = 0, cyc = 0;
    otpa_access #(.ADDR_W(9), .PROG_CYC(1)) dut (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .rd_req      (rd_req),
        .prog_req    (prog_req),
        .prog_all    (prog_all),
        .addr        (addr),
        .wdata       (wdata),
        .rdata_r     (rdata_r),
        .rvalid_r    (rvalid_r),
        .busy_r      (busy_r),
        .prog_done_r (prog_done_r)
    );
    initial forever #50 ref_clk = ~ref_clk;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_req <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_req <= 1'b0;
        // Answer stands for one cycle only, right after the wait state
        @(posedge ref_clk);
        #1;
        check({7'h00, rvalid_r}, 8'h01);
        check(rdata_r, exp);
    endtask
    // Read raised with the program request and held into the first busy cycle; it must not be served
    task prog(input logic [8:0] a, input logic [7:0] d, input logic all);
        int n;
        @(posedge ref_clk);
        prog_req <= 1'b1;
        prog_all <= all;
        addr <= a;
        wdata <= d;
        rd_req <= 1'b1;
        @(posedge ref_clk);
        prog_req <= 1'b0;
        @(posedge ref_clk);
        rd_req <= 1'b0;
        #1;
        check({7'h00, busy_r}, 8'h01);
        for (n = 0; n < 1100 && prog_done_r !== 1'b1; n++)
            @(posedge ref_clk) #1;
        check({7'h00, prog_done_r}, 8'h01);
        check({7'h00, busy_r}, 8'h00);
        check({7'h00, rvalid_r}, 8'h00);
    endtask
    task t_blank;
        rd(9'h000, 8'h00);
        rd(9'h1ff, 8'h00);
        $display("blank done");
    endtask
    task t_bytes;
        prog(9'h005, 8'h35, 1'b0);
        prog(9'h005, 8'h0a, 1'b0);
        rd(9'h005, 8'h3f);
        prog(9'h005, 8'h00, 1'b0);
        rd(9'h005, 8'h3f);
        rd(9'h006, 8'h00);
        prog(9'h1ff, 8'h5a, 1'b0);
        rd(9'h1ff, 8'h5a);
        $display("bytes done");
    endtask
    task t_all;
        prog(9'h000, 8'h81, 1'b1);
        rd(9'h000, 8'h81);
        rd(9'h005, 8'hbf);
        rd(9'h1ff, 8'hdb);
        $display("whole pass done");
    endtask
    task finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole pass needs about 1030 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            miscompares++;
            finish_test;
        end
    end
    initial
    begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        t_blank;
        t_bytes;
        t_all;
        finish_test;
    end
endmodule // otpa_access_test
